//--- core/casd_defines.vh
`ifndef CASD_DEFINES_VH
`define CASD_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
// status and core control keep their index; byte address is four times it
`define CASD_IDX_STATUS     12'h042
`define CASD_IDX_CORE       12'h044
`define CASD_OFS_STATUS     12'h108
`define CASD_OFS_CORE       12'h110
`define CASD_OFS_OPA        12'h180
`define CASD_OFS_OPB        12'h184
`define CASD_OFS_CMD        12'h188
`define CASD_OFS_RESULT     12'h18c
`define CASD_OFS_RESHI      12'h190
`define CASD_OFS_BUSY       12'h194
`define CASD_OFS_WREG       12'h200
// ----------------------------------------
// status word fields
// ----------------------------------------
`define CASD_SR_C           0
`define CASD_SR_Z           1
`define CASD_SR_OV          2
`define CASD_SR_N           3
`define CASD_SR_LOOP        4
`define CASD_SR_PRI_LO      5
`define CASD_SR_PRI_HI      7
`define CASD_SR_DC          8
`define CASD_SR_RESET       16'h0000
// ----------------------------------------
// core control fields
// ----------------------------------------
`define CASD_CC_WIN         2
`define CASD_CC_UPPER       3
`define CASD_CC_RESET       16'h0000
// ----------------------------------------
// command field layout and opcodes
// ----------------------------------------
`define CASD_CMD_OP_HI      3
`define CASD_CMD_BYTE       4
`define CASD_CMD_DST_MEM    5
`define CASD_CMD_SRC_MEM    6
`define CASD_CMD_SIGNA      7
`define CASD_CMD_SIGNB      8
`define CASD_CMD_LONG       9
`define CASD_CMD_RA_LO      12
`define CASD_CMD_RB_LO      16
`define CASD_CMD_RD_LO      20
`define CASD_CMD_LIT_LO     24
`define CASD_OP_ADD         4'h0
`define CASD_OP_SUB         4'h1
`define CASD_OP_AND         4'h2
`define CASD_OP_OR          4'h3
`define CASD_OP_XOR         4'h4
`define CASD_OP_SHIFT       4'h5
`define CASD_OP_MUL         4'h6
`define CASD_OP_MULLIT      4'h7
`define CASD_OP_DIV         4'h8
`define CASD_OP_MUL8        4'h9
// ----------------------------------------
// timing counts
// ----------------------------------------
`define CASD_DIV_BITS       5'h10
`define CASD_DIV_TOTAL      5'h13
`endif

//--- core/casd_datapath.v
// Operation
// - 16-bit alu adds, subtracts, shifts, logic ops
// - byte or word operand size per command
// - first operand from memory, register array or opA; second from opB
// - half carry from bit 4 or 8
// - carry from result msb
// - subtraction carries act as borrows
// - 3-bit priority field in status 7:5
// - upper priority bit above field disables user
// - priority field read-only while nesting disabled
// - status bit 4 shows repeat loop
// - core bit 2 enables program window
// - unimplemented bits read zero, ignore writes
// - 17x17 multiplier, sign modes, 8x8 mode
// - multiply by 5-bit unsigned literal
// - 32/16 and 16/16 signed/unsigned division
// - quotient to reg zero, remainder reg one
// - any divisor reg, even pair dividend
// - one cycle per divisor bit
// - divide totals 19 cycles, interruptible
// - single-cycle shifts up to 16 bits
// - signed amount: positive right, negative left
`include "casd_defines.vh"
`default_nettype none
module casd_datapath (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        nestingDisable,
    input  wire        raisePriority,
    input  wire        divHold,
    input  wire [15:0] memRdata,
    output reg  [15:0] memWdata,
    output reg         memWe,
    output reg         programWindowEnable,
    output reg         userIrqDisable,
    output reg  [3:0]  cpuPriority
);
// ----------------------------------------
// state
// ----------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_DIV  = 3'b010;
localparam [2:0] ST_TAIL = 3'b100;
localparam [15:0] SR_RST = `CASD_SR_RESET;
localparam [15:0] CC_RST = `CASD_CC_RESET;
reg  [15:0] wreg_q [0:15];
reg  [8:0]  sr_q;
reg         upper_q;
reg         win_q;
reg  [15:0] opA_q;
reg  [15:0] opB_q;
reg  [31:0] cmd_q;
reg  [15:0] res_q;
reg  [15:0] resHi_q;
reg  [2:0]  state_q;
reg  [4:0]  cnt_q;
reg  [31:0] rem_q;
reg  [15:0] quo_q;
reg  [15:0] dvs_q;
reg         negQ_q;
reg         negR_q;
wire        wrEn  = psel & penable & pwrite;
wire [3:0]  op    = cmd_q[`CASD_CMD_OP_HI:0];
wire        isByte = cmd_q[`CASD_CMD_BYTE];
wire        sA    = cmd_q[`CASD_CMD_SIGNA];
wire        sB    = cmd_q[`CASD_CMD_SIGNB];
wire [3:0]  ra    = cmd_q[`CASD_CMD_RA_LO+3:`CASD_CMD_RA_LO];
wire [3:0]  rb    = cmd_q[`CASD_CMD_RB_LO+3:`CASD_CMD_RB_LO];
wire [3:0]  rd    = cmd_q[`CASD_CMD_RD_LO+3:`CASD_CMD_RD_LO];
wire [4:0]  lit   = cmd_q[`CASD_CMD_LIT_LO+4:`CASD_CMD_LIT_LO];
wire        cmdGo = wrEn & (paddr == `CASD_OFS_CMD) & (state_q == ST_IDLE);
// ----------------------------------------
// operand fetch
// ----------------------------------------
reg  [15:0] a;
reg  [15:0] b;
always @* begin
    a = cmd_q[`CASD_CMD_SRC_MEM] ? memRdata : wreg_q[ra];
    b = opB_q;
    if (cmd_q[`CASD_CMD_SRC_MEM] == 1'b0 && opA_q != 16'h0000) begin
        a = opA_q;
    end
end
// ----------------------------------------
// alu
// ----------------------------------------
reg  [16:0] sum;
reg  [15:0] r;
reg  [15:0] hc;
reg         fC;
reg         fDC;
reg         fOV;
reg  [15:0] mB;
reg         msbA;
reg         msbB;
reg         msbR;
reg  [31:0] shr;
reg  [15:0] mag;
reg  signed [33:0] prod;
always @* begin
    mB   = (op == `CASD_OP_SUB) ? ~b : b;
    sum  = {1'b0, a} + {1'b0, mB} + {16'h0000, op == `CASD_OP_SUB};
    hc   = a ^ mB ^ sum[15:0];
    r    = sum[15:0];
    fC   = isByte ? hc[8] ^ 1'b0 : sum[16];
    if (isByte) begin
        fC = (a[7:0] + mB[7:0] + {7'h00, op == `CASD_OP_SUB}) > 9'h0ff;
    end
    fDC  = isByte ? hc[4] : hc[8];
    if (op == `CASD_OP_SUB) begin
        fC  = ~fC;
        fDC = ~fDC;
    end
    msbA = isByte ? a[7] : a[15];
    msbB = isByte ? mB[7] : mB[15];
    shr  = 32'h00000000;
    mag  = 16'h0000;
    prod = 34'h000000000;
    case (op)
        `CASD_OP_AND: r = a & b;
        `CASD_OP_OR:  r = a | b;
        `CASD_OP_XOR: r = a ^ b;
        `CASD_OP_SHIFT: begin
            // signed amount, one cycle barrel
            mag = b[15] ? (~b + 16'h0001) : b;
            if (b[15]) begin
                r = (mag > 16'h0010) ? 16'h0000 : a << mag[4:0];
            end else begin
                shr = {{16{sA & a[15]}}, a} >> mag[4:0];
                r   = (mag > 16'h0010) ? {16{sA & a[15]}} : shr[15:0];
            end
        end
        `CASD_OP_MUL: begin
            // 17x17 signed product covers all sign mixes
            prod = $signed({sA & a[15], a}) * $signed({sB & b[15], b});
            r    = prod[15:0];
        end
        `CASD_OP_MULLIT: begin
            prod = $signed({sA & a[15], a}) * $signed({12'h000, lit});
            r    = prod[15:0];
        end
        `CASD_OP_MUL8: begin
            prod = $signed({9'h000, a[7:0]}) * $signed({9'h000, b[7:0]});
            r    = prod[15:0];
        end
        default: ;
    endcase
    if (isByte) begin
        r[15:8] = a[15:8];
    end
    msbR = isByte ? r[7] : r[15];
    fOV  = (msbA == msbB) & (msbR != msbA);
end
wire isArith = (op == `CASD_OP_ADD) | (op == `CASD_OP_SUB);
wire zeroRes = isByte ? (r[7:0] == 8'h00) : (r == 16'h0000);
// ----------------------------------------
// divider: one cycle per divisor bit
// ----------------------------------------
wire [31:0] dvdW = cmd_q[`CASD_CMD_LONG] ? {wreg_q[{rb[3:1], 1'b1}], wreg_q[{rb[3:1], 1'b0}]}
                                         : {{16{sA & wreg_q[rb][15]}}, wreg_q[rb]};
wire [15:0] dvsW = wreg_q[ra];
wire [31:0] dvdAbs = (sA & dvdW[31]) ? (~dvdW + 32'h00000001) : dvdW;
wire [15:0] dvsAbs = (sA & dvsW[15]) ? (~dvsW + 16'h0001) : dvsW;
wire [16:0] trial = {rem_q[31:15]} - {1'b0, dvs_q};
wire [15:0] quoOut = negQ_q ? (~quo_q + 16'h0001) : quo_q;
wire [15:0] remOut = negR_q ? (~rem_q[31:16] + 16'h0001) : rem_q[31:16];
integer i;
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        for (i = 0; i < 16; i = i + 1) begin
            wreg_q[i] <= 16'h0000;
        end
        sr_q     <= SR_RST[8:0];
        upper_q  <= CC_RST[`CASD_CC_UPPER];
        win_q    <= CC_RST[`CASD_CC_WIN];
        opA_q    <= 16'h0000;
        opB_q    <= 16'h0000;
        cmd_q    <= 32'h00000000;
        res_q    <= 16'h0000;
        resHi_q  <= 16'h0000;
        state_q  <= ST_IDLE;
        cnt_q    <= 5'h00;
        rem_q    <= 32'h00000000;
        quo_q    <= 16'h0000;
        dvs_q    <= 16'h0000;
        negQ_q   <= 1'b0;
        negR_q   <= 1'b0;
        memWe    <= 1'b0;
        memWdata <= 16'h0000;
    end else begin
        memWe <= 1'b0;
        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (wrEn && paddr == `CASD_OFS_STATUS) begin
            if (pstrb[0]) begin
                sr_q[3:0] <= pwdata[3:0];
                if (!nestingDisable) begin
                    sr_q[7:5] <= pwdata[7:5];
                end
            end
            if (pstrb[1]) begin
                sr_q[8] <= pwdata[8];
            end
        end
        if (wrEn && paddr == `CASD_OFS_CORE && pstrb[0]) begin
            win_q <= pwdata[`CASD_CC_WIN];
            if (!pwdata[`CASD_CC_UPPER]) begin
                upper_q <= 1'b0;
            end
        end
        if (raisePriority) begin
            upper_q <= 1'b1;
        end
        if (wrEn && paddr == `CASD_OFS_OPA) begin
            opA_q <= pwdata[15:0];
        end
        if (wrEn && paddr == `CASD_OFS_OPB) begin
            opB_q <= pwdata[15:0];
        end
        if (wrEn && paddr[11:6] == `CASD_OFS_WREG >> 6 && state_q == ST_IDLE) begin
            wreg_q[paddr[5:2]] <= pwdata[15:0];
        end
        if (cmdGo) begin
            cmd_q <= pwdata;
        end
        // ----------------------------------------
        // execute
        // ----------------------------------------
        case (state_q)
            ST_IDLE: begin
                if (cmdGo && pwdata[`CASD_CMD_OP_HI:0] == `CASD_OP_DIV) begin
                    state_q <= ST_DIV;
                    cnt_q   <= 5'h00;
                end else if (cmdGo) begin
                    state_q <= ST_TAIL;
                    cnt_q   <= 5'h00;
                end
            end
            ST_DIV: begin
                sr_q[`CASD_SR_LOOP] <= 1'b1;
                if (!divHold) begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h00) begin
                        rem_q  <= dvdAbs;
                        dvs_q  <= dvsAbs;
                        negQ_q <= sA & (dvdW[31] ^ dvsW[15]);
                        negR_q <= sA & dvdW[31];
                    end else if (cnt_q <= `CASD_DIV_BITS) begin
                        // restoring step, one quotient bit per cycle
                        if (!trial[16]) begin
                            rem_q <= {trial[15:0], rem_q[14:0], 1'b0};
                            quo_q <= {quo_q[14:0], 1'b1};
                        end else begin
                            rem_q <= {rem_q[30:0], 1'b0};
                            quo_q <= {quo_q[14:0], 1'b0};
                        end
                    end else if (cnt_q == `CASD_DIV_TOTAL - 5'h01) begin
                        wreg_q[0] <= quoOut;
                        wreg_q[1] <= remOut;
                        res_q     <= quoOut;
                        resHi_q   <= remOut;
                        state_q   <= ST_IDLE;
                        sr_q[`CASD_SR_LOOP] <= 1'b0;
                    end
                end
            end
            ST_TAIL: begin
                state_q <= ST_IDLE;
                res_q   <= r;
                resHi_q <= prod[31:16];
                if (cmd_q[`CASD_CMD_DST_MEM]) begin
                    memWe    <= 1'b1;
                    memWdata <= r;
                end else begin
                    wreg_q[rd] <= r;
                end
                sr_q[`CASD_SR_N] <= msbR;
                sr_q[`CASD_SR_Z] <= zeroRes;
                if (isArith) begin
                    sr_q[`CASD_SR_C]  <= fC;
                    sr_q[`CASD_SR_DC] <= fDC;
                    sr_q[`CASD_SR_OV] <= fOV;
                end
            end
            default: state_q <= ST_IDLE;
        endcase
    end
end
// ----------------------------------------
// apb read side and pin outputs
// ----------------------------------------
reg [31:0] rdMux;
always @* begin
    case (paddr)
        `CASD_OFS_STATUS: rdMux = {23'h000000, sr_q};
        `CASD_OFS_CORE:   rdMux = {28'h0000000, upper_q, win_q, 2'b00};
        `CASD_OFS_OPA:    rdMux = {16'h0000, opA_q};
        `CASD_OFS_OPB:    rdMux = {16'h0000, opB_q};
        `CASD_OFS_CMD:    rdMux = cmd_q;
        `CASD_OFS_RESULT: rdMux = {16'h0000, res_q};
        `CASD_OFS_RESHI:  rdMux = {16'h0000, resHi_q};
        `CASD_OFS_BUSY:   rdMux = {29'h00000000, state_q};
        default:          rdMux = (paddr[11:6] == `CASD_OFS_WREG >> 6) ? {16'h0000, wreg_q[paddr[5:2]]}
                                                                     : 32'h00000000;
    endcase
end
wire mapped = (paddr[11:6] == `CASD_OFS_WREG >> 6) | (paddr == `CASD_OFS_STATUS) | (paddr == `CASD_OFS_CORE)
            | (paddr >= `CASD_OFS_OPA && paddr <= `CASD_OFS_BUSY && paddr[1:0] == 2'b00);
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        prdata              <= 32'h00000000;
        pready              <= 1'b0;
        pslverr             <= 1'b0;
        programWindowEnable <= 1'b0;
        userIrqDisable      <= 1'b0;
        cpuPriority         <= 4'h0;
    end else begin
        // no wait state; read data is taken into a flop during setup
        pready  <= psel & ~penable;
        pslverr <= psel & ~penable & ~mapped;
        // writes answer zero so an error answer never carries stale data
        if (psel & ~penable) begin
            prdata <= pwrite ? 32'h00000000 : rdMux;
        end
        programWindowEnable <= win_q;
        cpuPriority         <= {upper_q, sr_q[`CASD_SR_PRI_HI:`CASD_SR_PRI_LO]};
        userIrqDisable      <= upper_q | (sr_q[`CASD_SR_PRI_HI:`CASD_SR_PRI_LO] == 3'h7);
    end
end
endmodule
`default_nettype wire

//--- tb/casd_asserts.sv
`include "casd_defines.vh"
`default_nettype none
module casd_asserts (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        nestingDisable,
    input wire logic        raisePriority,
    input wire logic        divHold,
    input wire logic [15:0] memRdata,
    input wire logic [15:0] memWdata,
    input wire logic        memWe,
    input wire logic        programWindowEnable,
    input wire logic        userIrqDisable,
    input wire logic [3:0]  cpuPriority
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // priority and control
    // ----------------------------------------
    AST_IRQ_DISABLE: assert property (userIrqDisable == (cpuPriority[3] || cpuPriority[2:0] == 3'h7))
        else $error("user irq disable disagrees with priority");
    AST_RAISE: assert property (raisePriority |-> ##[1:2] cpuPriority[3])
        else $error("raise did not set upper priority bit");
    AST_UPPER_SET_ONLY_HW: assert property ($rose(cpuPriority[3]) |-> $past(raisePriority) || $past(raisePriority, 2))
        else $error("upper priority bit set without raise");
    AST_NEST_FREEZE: assert property (nestingDisable [*3] |-> $stable(cpuPriority[2:0]))
        else $error("priority field moved while nesting disabled");
    AST_PRIO_FROM_WRITE: assert property ($changed(cpuPriority[2:0]) |-> $past(psel && penable && pwrite && paddr == `CASD_OFS_STATUS, 2))
        else $error("priority field changed without status write");
    AST_WINDOW: assert property ($changed(programWindowEnable) |-> $past(psel && penable && pwrite && paddr == `CASD_OFS_CORE, 2))
        else $error("window enable changed without core write");
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    AST_UNMAPPED: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without ready or with data");
    AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_MEMWE_PULSE: assert property (memWe |=> !memWe)
        else $error("memory write strobe longer than one cycle");
    cover property (raisePriority ##2 cpuPriority[3]);
    cover property (memWe);
    cover property (pslverr);
    cover property ($rose(programWindowEnable));
endmodule
bind casd_datapath casd_asserts i_chk (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nestingDisable(nestingDisable), .raisePriority(raisePriority),
    .divHold(divHold), .memRdata(memRdata), .memWdata(memWdata), .memWe(memWe),
    .programWindowEnable(programWindowEnable), .userIrqDisable(userIrqDisable), .cpuPriority(cpuPriority)
);
`default_nettype wire

//--- tb/tb.sv
`include "casd_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ST = `CASD_OFS_STATUS;
    localparam logic [11:0] CC = `CASD_OFS_CORE;
    localparam logic [11:0] BZ = `CASD_OFS_BUSY;
    localparam logic [11:0] HI = `CASD_OFS_RESHI;
    logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        nestingDisable = 1'b0, raisePriority = 1'b0, divHold = 1'b0, lastErr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdq = 32'h0;
    logic [3:0]  cpuPriority;
    logic [15:0] memRdata = 16'h0, memWdata, memSeen = 16'h0;
    logic        pready, pslverr, memWe, programWindowEnable, userIrqDisable;
    int          fail_count = 0, cmp_count = 0;
    casd_datapath i_dut (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nestingDisable(nestingDisable), .raisePriority(raisePriority),
        .divHold(divHold), .memRdata(memRdata), .memWdata(memWdata), .memWe(memWe),
        .programWindowEnable(programWindowEnable), .userIrqDisable(userIrqDisable), .cpuPriority(cpuPriority)
    );
    initial begin
        forever #4 clock = ~clock;
    end
    // strobe is a pulse, so catch it on the edge it stands
    always @(posedge clock) begin
        if (memWe === 1'b1) memSeen <= memWdata;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task give_verdict;
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // holds the request until pready is seen high at an edge, then idles one cycle
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                check(32'h0, 32'h1);
                give_verdict;
            end
            @(posedge clock);
        end
        rdq = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdq, exp);
    endtask
    task settle;
        repeat (2) @(posedge clock);
    endtask
    task wait_idle;
        int n;
        n = 0;
        rdq = 32'h0;
        while (rdq !== 32'h1) begin
            apb(1'b0, BZ, 32'h0);
            n++;
            if (n > 100) begin
                check(rdq, 32'h1);
                give_verdict;
            end
        end
    endtask
    // status cleared first so flags not touched by an op read zero; sr of ffff skips the flag check
    task do_op(input logic [31:0] c, input logic [15:0] a, b, res, sr);
        wr(ST, 32'h0);
        wr(`CASD_OFS_OPA, {16'h0, a});
        wr(`CASD_OFS_OPB, {16'h0, b});
        wr(`CASD_OFS_CMD, c);
        wait_idle;
        rdchk(`CASD_OFS_RESULT, {16'h0, res});
        if (sr !== 16'hffff) rdchk(ST, {16'h0, sr});
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rdchk(ST, 32'h0);
        rdchk(CC, 32'h0);
        wr(ST, 32'hffff);
        rdchk(ST, 32'h01ef);
        settle;
        check({28'h0, cpuPriority}, 32'h7);
        check({31'h0, userIrqDisable}, 32'h1);
        nestingDisable <= 1'b1;
        wr(ST, 32'h0);
        rdchk(ST, 32'h00e0);
        nestingDisable <= 1'b0;
        wr(ST, 32'h0);
        rdchk(ST, 32'h0);
        wr(CC, 32'hffff);
        rdchk(CC, 32'h4);
        settle;
        check({31'h0, programWindowEnable}, 32'h1);
        raisePriority <= 1'b1;
        @(posedge clock);
        raisePriority <= 1'b0;
        rdchk(CC, 32'hc);
        settle;
        check({28'h0, cpuPriority}, 32'h8);
        check({31'h0, userIrqDisable}, 32'h1);
        wr(CC, 32'h0);
        rdchk(CC, 32'h0);
        settle;
        check({31'h0, programWindowEnable}, 32'h0);
        check({31'h0, userIrqDisable}, 32'h0);
        wr(12'h3fc, 32'hffff);
        check({31'h0, lastErr}, 32'h1);
        rdchk(12'h3fc, 32'h0);
        do_op(32'h00700000, 16'h7fff, 16'h0001, 16'h8000, 16'h010c);
        rdchk(`CASD_OFS_WREG + 12'h01c, 32'h8000);
        do_op(32'h00700000, 16'hffff, 16'h0001, 16'h0000, 16'h0103);
        do_op(32'h00700001, 16'h0001, 16'h0002, 16'hffff, 16'h0109);
        do_op(32'h00700001, 16'h8000, 16'h0001, 16'h7fff, 16'h0104);
        do_op(32'h00700010, 16'h12ff, 16'h0001, 16'h1200, 16'h0103);
        do_op(32'h00700002, 16'hf0f0, 16'h0f0f, 16'h0000, 16'h0002);
        do_op(32'h00700003, 16'h8000, 16'h0001, 16'h8001, 16'h0008);
        do_op(32'h00700004, 16'h0f0f, 16'h00ff, 16'h0ff0, 16'h0000);
        do_op(32'h00700005, 16'h8000, 16'h0004, 16'h0800, 16'h0000);
        do_op(32'h00700085, 16'h8000, 16'h0004, 16'hf800, 16'h0008);
        do_op(32'h00700005, 16'h0001, 16'hfffc, 16'h0010, 16'h0000);
        do_op(32'h00700005, 16'h8000, 16'h0000, 16'h8000, 16'h0008);
        do_op(32'h00700005, 16'h8000, 16'h0010, 16'h0000, 16'h0002);
        do_op(32'h00700005, 16'hffff, 16'hfff0, 16'h0000, 16'h0002);
        do_op(32'h00700006, 16'hffff, 16'hffff, 16'h0001, 16'hffff);
        rdchk(HI, 32'hfffe);
        do_op(32'h00700186, 16'hffff, 16'hffff, 16'h0001, 16'hffff);
        rdchk(HI, 32'h0);
        do_op(32'h00700106, 16'hffff, 16'hffff, 16'h0001, 16'hffff);
        rdchk(HI, 32'hffff);
        do_op(32'h1f700007, 16'h0003, 16'h0000, 16'h005d, 16'hffff);
        do_op(32'h00700009, 16'h12ff, 16'h34ff, 16'hfe01, 16'hffff);
        memRdata <= 16'h0100;
        do_op(32'h00700060, 16'h0000, 16'h0023, 16'h0123, 16'h0000);
        check({16'h0, memSeen}, 32'h0123);
        wr(`CASD_OFS_WREG + 12'h008, 32'h0);
        wr(`CASD_OFS_WREG + 12'h00c, 32'h1);
        wr(`CASD_OFS_WREG + 12'h010, 32'h3);
        wr(`CASD_OFS_WREG + 12'h014, 32'h2);
        wr(`CASD_OFS_WREG + 12'h018, 32'hfff9);
        wr(ST, 32'h0);
        divHold <= 1'b1;
        wr(`CASD_OFS_CMD, 32'h00024208);
        repeat (40) @(posedge clock);
        rdchk(BZ, 32'h2);
        apb(1'b0, ST, 32'h0);
        check(rdq & 32'h10, 32'h10);
        divHold <= 1'b0;
        // setup lands on the nineteenth unheld cycle, still busy
        repeat (18) @(posedge clock);
        rdchk(BZ, 32'h2);
        wait_idle;
        rdchk(`CASD_OFS_WREG, 32'h5555);
        rdchk(`CASD_OFS_WREG + 12'h004, 32'h1);
        apb(1'b0, ST, 32'h0);
        check(rdq & 32'h10, 32'h0);
        wr(`CASD_OFS_CMD, 32'h00065188);
        // setup lands one cycle past the nineteenth, so idle again
        repeat (18) @(posedge clock);
        rdchk(BZ, 32'h1);
        wait_idle;
        rdchk(`CASD_OFS_WREG, 32'hfffd);
        rdchk(`CASD_OFS_WREG + 12'h004, 32'hffff);
        give_verdict;
    end
endmodule
`default_nettype wire
